/* ufpc_chk.sv */
// Purpose: Port-level assertions for the frequency/period counter.
// Assumes: Gate lengths handed on from the design's parameters.
// Notes: Gate length is judged only when setup held still.
`timescale 1ns/10ps
module ufpc_chk #(
   parameter [27:0] P_GATE0_CYC = 28'h1,
   parameter [27:0] P_GATE1_CYC = 28'h1,
   parameter [27:0] P_GATE2_CYC = 28'h1,
   parameter [27:0] P_GATE3_CYC = 28'h1
) (
   // Clock, reset and setup
   input wire i_ref_clk,
   input wire i_rst,
   input wire [2:0] i_mode,
   input wire [2:0] i_gate_or_average_select,
   input wire i_mult_disable,
   input wire i_hold,
   // Display and lamps
   input wire [23:0] o_count,
   input wire [2:0] o_dp,
   input wire o_dp_show,
   input wire o_overflow,
   input wire o_gate,
   input wire o_mult_lock
);
   reg [27:0] glen_q;
   reg chg_q;
   wire [1:0] gs = i_gate_or_average_select[1:0];
   wire [27:0] gexp = gs[1] ? (gs[0] ? P_GATE3_CYC : P_GATE2_CYC) :
      (gs[0] ? P_GATE1_CYC : P_GATE0_CYC);
   // Multiplier range loss restarts the gate, so those gates are skipped
   always @(posedge i_ref_clk) begin
      if (i_rst || !o_gate) begin
         glen_q <= 28'h0;
         chg_q <= 1'b0;
      end else begin
         glen_q <= glen_q + 28'h1;
         if (o_mult_lock || $changed({i_mode, i_gate_or_average_select, i_mult_disable}))
            chg_q <= 1'b1;
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   property p_rst_clear;
      $fell(i_rst) |-> !o_gate && !o_overflow && !o_mult_lock && o_count == 24'h0 && o_dp == 3'h0;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
   property p_gate_len;
      $fell(o_gate) && i_mode < 3'h2 && !i_gate_or_average_select[2] && !chg_q |-> glen_q == gexp;
   endproperty
   a_gate_len: assert property (p_gate_len) else $error("gate length wrong");
   property p_disp_stand;
      o_gate |-> $stable(o_count) && $stable(o_overflow) && $stable(o_dp);
   endproperty
   a_disp_stand: assert property (p_disp_stand) else $error("display moved in gate");
   property p_lock_direct;
      o_mult_lock && o_gate |-> $past(i_mode) == 3'h0 && !$past(i_mult_disable);
   endproperty
   a_lock_direct: assert property (p_lock_direct) else $error("lock out of mode");
   property p_no_point;
      o_dp == 3'h6 |-> !o_dp_show;
   endproperty
   a_no_point: assert property (p_no_point) else $error("point shown");
   property p_point;
      o_dp != 3'h0 && o_dp != 3'h6 |-> o_dp_show;
   endproperty
   a_point: assert property (p_point) else $error("point missing");
   property p_hold;
      $rose(o_gate) && i_mode < 3'h2 |-> !$past(i_hold, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("gate opened in hold");
   property p_latch;
      $changed(o_count) |-> !o_gate && !$past(o_gate) && $past(o_gate, 2);
   endproperty
   a_latch: assert property (p_latch) else $error("count moved off gate close");
endmodule
bind ufpc_counter ufpc_chk #(.P_GATE0_CYC(P_GATE0_CYC), .P_GATE1_CYC(P_GATE1_CYC),
   .P_GATE2_CYC(P_GATE2_CYC), .P_GATE3_CYC(P_GATE3_CYC)) i_ufpc_chk (.i_ref_clk, .i_rst,
   .i_mode, .i_gate_or_average_select, .i_mult_disable, .i_hold, .o_count, .o_dp,
   .o_dp_show, .o_overflow, .o_gate, .o_mult_lock);

/* ufpc_counter.v */
// Purpose: Measurement control of a six-digit frequency/period/width counter.
// Assumes: Inputs arrive already shaped; the x100 loop is outside.
// Notes: Display is BCD, digit 5 leftmost; o_dp counts digits right of point.
// Functional notes
// - Frequency: count input events while gate open
// - Period: count time base over N events
// - Gate times 0.01, 0.1, 1, 10 s
// - Prescaled mode divides input events by ten
// - Direct mode uses x100 path 10 Hz-25 kHz
// - Option disables the automatic multiplier path
// - Lock lamp while multiplier used, direct only
// - Multiplier with 10 s gate: no point shown
// - Overflow on carry out of top decade
// - Counted time base is 10 MHz
// - Period averaging up to 1000 events
// - Last digit weight scales with averaged count
// - Auto range fills display, at most 100 averages
// - Auto period over 100 ms overflows display
// - Width gate: selected slope to opposite slope
// - First pulse arms, next N pulses measured
`timescale 1ns/10ps
`include "ufpc_defines.vh"

module ufpc_counter #(
   parameter [27:0] P_GATE0_CYC = `UFPC_GATE0_MS * `UFPC_CLK_KHZ,
   parameter [27:0] P_GATE1_CYC = `UFPC_GATE1_MS * `UFPC_CLK_KHZ,
   parameter [27:0] P_GATE2_CYC = `UFPC_GATE2_MS * `UFPC_CLK_KHZ,
   parameter [27:0] P_GATE3_CYC = `UFPC_GATE3_MS * `UFPC_CLK_KHZ,
   parameter [20:0] P_MULT_MAX_CYC = `UFPC_MULT_MAX_US * `UFPC_CLK_MHZ
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_rst,
   // Measurement setup
   input wire [2:0] i_mode,
   input wire [2:0] i_gate_or_average_select,
   input wire i_mult_disable,
   input wire i_hold,
   // Shaped signals
   input wire i_sig,
   input wire i_mult_sig,
   // Display and lamps
   output wire [23:0] o_count,
   output wire [2:0] o_dp,
   output wire o_dp_show,
   output wire o_overflow,
   output wire o_gate,
   output wire o_mult_lock
);

   localparam [4:0] S_CLR = 5'h01;
   localparam [4:0] S_ARM = 5'h02;
   localparam [4:0] S_WAIT = 5'h04;
   localparam [4:0] S_GATE = 5'h08;
   localparam [4:0] S_DONE = 5'h10;
   localparam [20:0] MULT_MIN_CYC = `UFPC_MULT_MIN_US * `UFPC_CLK_MHZ;

   function [24:0] bcd_inc;
      input [23:0] v;
      integer k;
      reg c;
      reg [3:0] d;
      begin
         bcd_inc = {1'b0, v};
         c = 1'b1;
         for (k = 0; k < 6; k = k + 1) begin
            d = v[k*4 +: 4];
            if (c) begin
               if (d == 4'h9) begin
                  bcd_inc[k*4 +: 4] = 4'h0;
               end else begin
                  bcd_inc[k*4 +: 4] = d + 4'h1;
                  c = 1'b0;
               end
            end
         end
         bcd_inc[24] = c;
      end
   endfunction

   function [27:0] gate_len;
      input [1:0] i;
      begin
         case (i)
            2'h0: gate_len = P_GATE0_CYC;
            2'h1: gate_len = P_GATE1_CYC;
            2'h2: gate_len = P_GATE2_CYC;
            default: gate_len = P_GATE3_CYC;
         endcase
      end
   endfunction

   function [9:0] avg_n;
      input [1:0] i;
      begin
         case (i)
            2'h0: avg_n = `UFPC_AVG0;
            2'h1: avg_n = `UFPC_AVG1;
            2'h2: avg_n = `UFPC_AVG2;
            default: avg_n = `UFPC_AVG3;
         endcase
      end
   endfunction

   // Digits right of the point, display in kHz or microseconds
   function [2:0] dp_of;
      input presc;
      input [1:0] i;
      input mu;
      begin
         dp_of = {1'b0, i} + (presc ? 3'h0 : 3'h1) + (mu ? 3'h2 : 3'h0);
      end
   endfunction

   reg [2:0] sig_sync_q;
   reg [2:0] mul_sync_q;
   reg tb_q;
   reg [20:0] rng_cnt_q;
   reg in_range_q;
   reg [4:0] state_q;
   reg [27:0] gate_cnt_q;
   reg [9:0] ev_cnt_q;
   reg [23:0] acc_q;
   reg ovf_q;
   reg [3:0] pre_q;
   reg in_pulse_q;
   reg mult_act_q;
   reg [1:0] auto_idx_q;
   reg [6:0] cfg_q;
   reg [23:0] disp_q;
   reg [2:0] dp_q;
   reg dp_show_q;
   reg disp_ovf_q;
   reg cnt_en;

   // Stage 0 feeds only stage 1; edges look at stages 1 and 2
   wire sig_rise = sig_sync_q[1] & ~sig_sync_q[2];
   wire sig_fall = ~sig_sync_q[1] & sig_sync_q[2];
   wire mul_rise = mul_sync_q[1] & ~mul_sync_q[2];
   wire is_presc = (i_mode == `UFPC_MODE_PRESC);
   wire is_direct = (i_mode == `UFPC_MODE_DIRECT);
   wire is_freq = is_direct | is_presc;
   wire is_neg = (i_mode == `UFPC_MODE_WNEG);
   wire is_width = (i_mode == `UFPC_MODE_WPOS) | is_neg;
   wire src_rise = is_neg ? sig_fall : sig_rise;
   wire src_fall = is_neg ? sig_rise : sig_fall;
   wire sel_auto = (i_gate_or_average_select == `UFPC_SEL_AUTO);
   wire [1:0] idx = sel_auto ? auto_idx_q : i_gate_or_average_select[1:0];
   wire [6:0] cfg = {i_mode, i_gate_or_average_select, i_mult_disable};
   wire tick = tb_q;
   wire ev_freq = mult_act_q ? mul_rise : sig_rise;
   wire [24:0] acc_inc = bcd_inc(acc_q);
   wire [9:0] ev_next = ev_cnt_q + 10'h001;
   wire ev_last = (ev_next == avg_n(idx));

   always @* begin
      cnt_en = 1'b0;
      if (state_q == S_GATE) begin
         if (is_direct) begin
            cnt_en = ev_freq;
         end else if (is_presc) begin
            cnt_en = sig_rise & (pre_q == `UFPC_PRESC_LAST);
         end else if (is_width) begin
            cnt_en = tick & in_pulse_q;
         end else begin
            cnt_en = tick;
         end
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         sig_sync_q <= 3'h0;
         mul_sync_q <= 3'h0;
         tb_q <= 1'b0;
         rng_cnt_q <= 21'h000000;
         in_range_q <= 1'b0;
      end else begin
         sig_sync_q <= {sig_sync_q[1:0], i_sig};
         mul_sync_q <= {mul_sync_q[1:0], i_mult_sig};
         // Half rate enable gives the 10 MHz time base
         tb_q <= ~tb_q;
         // Input period decides whether the x100 path applies
         if (sig_rise) begin
            in_range_q <= (rng_cnt_q >= MULT_MIN_CYC) &&
                          (rng_cnt_q <= P_MULT_MAX_CYC);
            rng_cnt_q <= 21'h000001;
         end else if (rng_cnt_q <= P_MULT_MAX_CYC) begin
            rng_cnt_q <= rng_cnt_q + 21'h000001;
         end else begin
            in_range_q <= 1'b0;
         end
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         state_q <= S_CLR;
         gate_cnt_q <= 28'h0000000;
         ev_cnt_q <= 10'h000;
         acc_q <= 24'h000000;
         ovf_q <= 1'b0;
         pre_q <= 4'h0;
         in_pulse_q <= 1'b0;
         mult_act_q <= 1'b0;
         auto_idx_q <= 2'h0;
         cfg_q <= 7'h00;
         disp_q <= 24'h000000;
         dp_q <= 3'h0;
         dp_show_q <= 1'b0;
         disp_ovf_q <= 1'b0;
      end else begin
         cfg_q <= cfg;
         if (cnt_en) begin
            acc_q <= acc_inc[23:0];
            if (acc_inc[24]) begin
               ovf_q <= 1'b1;
            end
         end
         case (state_q)
            S_CLR: begin
               acc_q <= 24'h000000;
               ovf_q <= 1'b0;
               ev_cnt_q <= 10'h000;
               pre_q <= 4'h0;
               in_pulse_q <= 1'b0;
               mult_act_q <= is_direct & ~i_mult_disable & in_range_q;
               // Hold keeps the last reading and starts nothing new
               if (!i_hold) begin
                  state_q <= is_width ? S_ARM : S_WAIT;
               end
            end
            S_ARM: begin
               // Any pulse that ends arms; the next leading edge is measured
               if (src_fall) begin
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (is_freq) begin
                  gate_cnt_q <= gate_len(idx);
                  state_q <= S_GATE;
               end else if (src_rise) begin
                  in_pulse_q <= is_width;
                  state_q <= S_GATE;
               end
            end
            S_GATE: begin
               if (is_freq) begin
                  gate_cnt_q <= gate_cnt_q - 28'h0000001;
                  if (is_presc && sig_rise) begin
                     if (pre_q == `UFPC_PRESC_LAST) begin
                        pre_q <= 4'h0;
                     end else begin
                        pre_q <= pre_q + 4'h1;
                     end
                  end
                  if (gate_cnt_q == 28'h0000001) begin
                     state_q <= S_DONE;
                  end
               end else if (is_width) begin
                  if (src_rise) begin
                     in_pulse_q <= 1'b1;
                  end
                  if (src_fall && in_pulse_q) begin
                     in_pulse_q <= 1'b0;
                     ev_cnt_q <= ev_next;
                     if (ev_last) begin
                        state_q <= S_DONE;
                     end
                  end
               end else if (sig_rise) begin
                  ev_cnt_q <= ev_next;
                  if (ev_last) begin
                     state_q <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               disp_q <= acc_q;
               disp_ovf_q <= ovf_q;
               dp_q <= dp_of(is_presc, idx, mult_act_q);
               dp_show_q <= ~(mult_act_q && (idx == 2'h3));
               // Longer gate or more averages until the top digit is used or auto_idx_q reaches UFPC_AUTO_CAP
               if (sel_auto) begin
                  if (ovf_q && (auto_idx_q != 2'h0)) begin
                     auto_idx_q <= auto_idx_q - 2'h1;
                  end else if (!ovf_q && (acc_q[23:20] == 4'h0) &&
                               (auto_idx_q < `UFPC_AUTO_CAP)) begin
                     auto_idx_q <= auto_idx_q + 2'h1;
                  end
               end
               state_q <= S_CLR;
            end
            default: begin
               state_q <= S_CLR;
            end
         endcase
         // A changed setting or lost multiplier range voids the reading
         if ((cfg != cfg_q) || (mult_act_q && !in_range_q &&
             (state_q == S_GATE))) begin
            state_q <= S_CLR;
         end
      end
   end

   assign o_count = disp_q;
   assign o_dp = dp_q;
   assign o_dp_show = dp_show_q;
   assign o_overflow = disp_ovf_q;
   assign o_gate = state_q[3];
   assign o_mult_lock = mult_act_q;

endmodule

/* ufpc_counter_tb.sv */
// Purpose: Self-checking bench for the frequency/period counter.
// Assumes: Shortened gates of 20/40/60/80 cycles.
// Notes: Each row waits four gate closes so restarts settle.
`timescale 1ns/10ps
module ufpc_counter_tb;
   typedef struct packed {
      logic [2:0] m;
      logic [2:0] s;
      logic d;
      logic [15:0] h;
      logic [15:0] l;
      logic [23:0] c;
      logic [2:0] p;
      logic k;
   } ufpc_row_t;
   reg i_ref_clk = 1'b0;
   reg i_rst = 1'b1;
   reg [2:0] i_mode = 3'h0;
   reg [2:0] i_gate_or_average_select = 3'h0;
   reg i_mult_disable = 1'b0;
   reg i_hold = 1'b0;
   reg [15:0] hi = 16'h2;
   reg [15:0] lo = 16'h2;
   wire i_sig, i_mult_sig, o_dp_show, o_overflow, o_gate, o_mult_lock;
   wire [23:0] o_count;
   wire [2:0] o_dp;
   integer miscompares = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   ufpc_row_t rows [0:13];
   always #25 i_ref_clk = ~i_ref_clk;
   ufpc_counter #(.P_GATE0_CYC(28'h14), .P_GATE1_CYC(28'h28), .P_GATE2_CYC(28'h3c),
      .P_GATE3_CYC(28'h50), .P_MULT_MAX_CYC(21'h7d0)) i_ufpc_counter (.i_ref_clk, .i_rst,
      .i_mode, .i_gate_or_average_select, .i_mult_disable, .i_hold, .i_sig, .i_mult_sig,
      .o_count, .o_dp, .o_dp_show, .o_overflow, .o_gate, .o_mult_lock);
   ufpc_src i_ufpc_src (.i_clk(i_ref_clk), .i_hi(hi), .i_lo(lo), .o_sig(i_sig),
      .o_msig(i_mult_sig));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wait_fall(input integer n);
      integer k;
      for (k = 0; k < n; k = k + 1) begin
         while (o_gate !== 1'b1) @(posedge i_ref_clk);
         while (o_gate !== 1'b0) @(posedge i_ref_clk);
      end
      repeat (3) @(posedge i_ref_clk);
   endtask
   task run(input ufpc_row_t r);
      i_mode <= r.m;
      i_gate_or_average_select <= r.s;
      i_mult_disable <= r.d;
      hi <= r.h;
      lo <= r.l;
      // Multiplier range needs two slow input edges before it locks
      if (r.h > 16'h100)
         repeat (5000) @(posedge i_ref_clk);
      wait_fall(4);
      if (!r.d)
         chk("count", o_count, r.c);
      chk("dp", {21'h0, o_dp}, {21'h0, r.p});
      chk("lock", {23'h0, o_mult_lock}, {23'h0, r.k});
      chk("point", {23'h0, o_dp_show}, {23'h0, r.p != 3'h6});
      chk("ovf", {23'h0, o_overflow}, 24'h0);
      $display("row done mode %h select %h", r.m, r.s);
   endtask
   always @(posedge i_ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         miscompares = miscompares + 1;
         tally_and_finish;
      end
   end
   initial begin
      rows = '{'{3'h0, 3'h0, 1'b0, 16'h2, 16'h2, 24'h5, 3'h1, 1'b0},
         '{3'h0, 3'h2, 1'b0, 16'h2, 16'h2, 24'h15, 3'h3, 1'b0},
         '{3'h1, 3'h3, 1'b0, 16'h2, 16'h2, 24'h2, 3'h3, 1'b0},
         '{3'h1, 3'h1, 1'b0, 16'h2, 16'h2, 24'h1, 3'h1, 1'b0},
         '{3'h0, 3'h4, 1'b0, 16'h2, 16'h2, 24'h15, 3'h3, 1'b0},
         '{3'h2, 3'h0, 1'b0, 16'h14, 16'h14, 24'h20, 3'h1, 1'b0},
         '{3'h2, 3'h2, 1'b0, 16'h14, 16'h14, 24'h2000, 3'h3, 1'b0},
         '{3'h2, 3'h4, 1'b0, 16'h14, 16'h14, 24'h2000, 3'h3, 1'b0},
         '{3'h3, 3'h0, 1'b0, 16'h28, 16'h3c, 24'h20, 3'h1, 1'b0},
         '{3'h4, 3'h0, 1'b0, 16'h3c, 16'h28, 24'h20, 3'h1, 1'b0},
         '{3'h3, 3'h1, 1'b0, 16'h28, 16'h3c, 24'h200, 3'h2, 1'b0},
         '{3'h0, 3'h3, 1'b0, 16'h1f4, 16'h1f4, 24'h8, 3'h6, 1'b1},
         '{3'h0, 3'h3, 1'b1, 16'h1f4, 16'h1f4, 24'h0, 3'h4, 1'b0},
         '{3'h2, 3'h3, 1'b0, 16'h2, 16'h2, 24'h2000, 3'h4, 1'b0}};
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      for (i = 0; i < 14; i = i + 1)
         run(rows[i]);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      chk("rst count", o_count, 24'h0);
      chk("rst lamps", {22'h0, o_gate, o_mult_lock}, 24'h0);
      $display("reset test done");
      run(rows[0]);
      i_hold <= 1'b1;
      repeat (300) @(posedge i_ref_clk);
      chk("hold gate", {23'h0, o_gate}, 24'h0);
      chk("hold count", o_count, 24'h5);
      i_hold <= 1'b0;
      $display("hold test done");
      tally_and_finish;
   end
endmodule

/* ufpc_defines.vh */
// Purpose: Shared constants of the frequency/period counter.
// Assumes: 20 MHz system clock, 10 MHz counted time base.
// Notes: Times are in their own unit; cycle counts derive from them.
`ifndef UFPC_DEFINES_VH
`define UFPC_DEFINES_VH

`define UFPC_CLK_KHZ 20000
`define UFPC_CLK_MHZ 20

// Gate times in milliseconds
`define UFPC_GATE0_MS 10
`define UFPC_GATE1_MS 100
`define UFPC_GATE2_MS 1000
`define UFPC_GATE3_MS 10000

// Multiplier input period window, microseconds (25 kHz down to 10 Hz)
`define UFPC_MULT_MIN_US 40
`define UFPC_MULT_MAX_US 100000

// Function select
`define UFPC_MODE_DIRECT 3'h0
`define UFPC_MODE_PRESC 3'h1
`define UFPC_MODE_PERIOD 3'h2
`define UFPC_MODE_WPOS 3'h3
`define UFPC_MODE_WNEG 3'h4

// Gate or average select, value 4 is automatic range
`define UFPC_SEL_AUTO 3'h4
`define UFPC_AUTO_CAP 2'h2

// Averaging counts
`define UFPC_AVG0 10'h001
`define UFPC_AVG1 10'h00a
`define UFPC_AVG2 10'h064
`define UFPC_AVG3 10'h3e8

// Prescaler divides by ten
`define UFPC_PRESC_LAST 4'h9

`endif

/* ufpc_src.sv */
// Purpose: Shaped input source and x100 loop stand-in.
// Assumes: High and low times in reference clock cycles.
// Notes: Loop output runs at a fixed period of ten cycles.
`timescale 1ns/10ps
module ufpc_src (
   // Control
   input wire i_clk,
   input wire [15:0] i_hi,
   input wire [15:0] i_lo,
   // Shaped outputs
   output wire o_sig,
   output wire o_msig
);
   reg sig_q = 1'b0;
   reg msig_q = 1'b0;
   reg [15:0] cnt_q = 16'h0;
   reg [3:0] mcnt_q = 4'h0;
   assign o_sig = sig_q;
   assign o_msig = msig_q;
   always @(posedge i_clk) begin
      if (cnt_q + 16'h1 >= (sig_q ? i_hi : i_lo)) begin
         sig_q <= ~sig_q;
         cnt_q <= 16'h0;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
      mcnt_q <= (mcnt_q == 4'h4) ? 4'h0 : mcnt_q + 4'h1;
      if (mcnt_q == 4'h4)
         msig_q <= ~msig_q;
   end
endmodule
